// ### pbss_pkg.sv
package pbss_pkg;

   // reference clock
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_PERIOD_NS = 20;

   // straps latched this long after power-up
   localparam int POWER_LATCH_MS = 167;
   localparam int POWER_LATCH_CYC = POWER_LATCH_MS * (CLK_HZ / 1000);

   // straps re-latched this long after a hard or soft reset ends
   localparam int RESET_LATCH_US = 3;
   localparam int RESET_LATCH_CYC = RESET_LATCH_US * (CLK_HZ / 1_000_000);

   // latch to output-driver turnaround, rounded up to whole cycles
   localparam int DRIVE_TURN_NS = 50;
   localparam int DRIVE_TURN_CYC =
      (DRIVE_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // 100 Mb/s transmit latency, in bit times of 10 ns
   localparam int TX_LAT_BITS = 6;
   localparam int BIT_TIME_NS = 10;
   localparam int TX_LAT_CYC = (TX_LAT_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;

   // pin synchroniser depth; the stages after it, output flop included,
   // make up the rest of the transmit latency
   localparam int SYNC_STAGES = 2;
   localparam int TX_PIPE_CYC =
      (TX_LAT_CYC > SYNC_STAGES) ? TX_LAT_CYC - SYNC_STAGES : 1;

   // management preamble: mdio high for this many mdc cycles
   localparam int PREAMBLE_BITS = 32;
   localparam int PRE_CNT_W = 6;

   // sequencer counter wide enough for the power-up wait
   localparam int CNT_W = 24;

   // values after reset
   localparam logic STRAP_OE_RST = 1'b0;
   localparam logic STRAPS_VALID_RST = 1'b0;

   typedef enum logic [2:0]
   {
      PBSS_POWER,
      PBSS_HOLD,
      PBSS_SETTLE,
      PBSS_TURN,
      PBSS_RUN
   } pbss_state_t;

endpackage

// ### pbss_mgmt_if.sv
`timescale 1ns/1ps
interface pbss_mgmt_if;
   logic enable;
   logic mdc_rise;
   logic mdio_bit;
   logic preamble_seen;

   modport det
   (
      input enable,
      input mdc_rise,
      input mdio_bit,
      output preamble_seen
   );

   modport seq
   (
      output enable,
      output mdc_rise,
      output mdio_bit,
      input preamble_seen
   );
endinterface

// ### pbss_preamble_det.sv
`timescale 1ns/1ps
module pbss_preamble_det
   import pbss_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   pbss_mgmt_if.det mgmt
);

   logic [PRE_CNT_W-1:0] ones_reg;
   logic seen_reg;

   // counts consecutive high mdio bits on mdc rising edges, saturating
   always_ff @(posedge ref_clk)
   begin
      if (reset || !mgmt.enable)
      begin
         ones_reg <= '0;
      end
      else if (mgmt.mdc_rise)
      begin
         if (!mgmt.mdio_bit)
         begin
            ones_reg <= '0;
         end
         else if (ones_reg != PRE_CNT_W'(PREAMBLE_BITS))
         begin
            ones_reg <= ones_reg + PRE_CNT_W'(1);
         end
      end
   end

   // once seen the flag holds until the detector is disabled by a reset
   always_ff @(posedge ref_clk)
   begin
      if (reset || !mgmt.enable)
      begin
         seen_reg <= 1'b0;
      end
      else if (ones_reg == PRE_CNT_W'(PREAMBLE_BITS))
      begin
         seen_reg <= 1'b1;
      end
   end

   assign mgmt.preamble_seen = seen_reg;

endmodule

// ### pbss_top.sv
`timescale 1ns/1ps
module pbss_top
   import pbss_pkg::*;
#(
   parameter int STRAP_W = 8,
   parameter int POWER_CYC = POWER_LATCH_CYC
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic hard_reset_n,
   input wire logic soft_reset,
   input wire logic [STRAP_W-1:0] strap_in,
   input wire logic [STRAP_W-1:0] func_out,
   output logic [STRAP_W-1:0] strap_out,
   output logic [STRAP_W-1:0] strap_oe,
   output logic [STRAP_W-1:0] strap_value,
   output logic straps_valid,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mgmt_ready,
   input wire logic speed_100,
   input wire logic tx_clk,
   input wire logic tx_en,
   output logic line_tx_active
);

   localparam int PIN_W = STRAP_W + 6;

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] sync1_reg;
   logic [PIN_W-1:0] sync2_reg;
   logic hard_n_s;
   logic mdc_s;
   logic mdio_s;
   logic tx_clk_s;
   logic tx_en_s;
   logic speed_s;
   logic [STRAP_W-1:0] strap_s;
   logic mdc_prev_reg;
   logic tx_clk_prev_reg;
   logic in_reset;

   pbss_state_t state_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic latch_now;
   logic drive_now;

   logic [STRAP_W-1:0] strap_value_reg;
   logic straps_valid_reg;
   logic [STRAP_W-1:0] strap_oe_reg;
   logic [STRAP_W-1:0] strap_out_reg;
   logic mgmt_ready_reg;

   logic tx_level_reg;
   logic tx_en_prev_reg;
   logic tx_rise;
   logic tx_level_next;
   logic [TX_PIPE_CYC-1:0] tx_pipe_reg;

   pbss_mgmt_if mgmt ();

   // every pin from outside except reset, soft_reset and func_out passes two flops before any logic reads it
   assign pin_raw = {strap_in, speed_100, tx_en, tx_clk, mdio_in, mdc,
                     hard_reset_n};

   // ones after reset: hard reset reads released, no false clock rise
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sync1_reg <= '1;
         sync2_reg <= '1;
      end
      else
      begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end

   assign hard_n_s = sync2_reg[0];
   assign mdc_s = sync2_reg[1];
   assign mdio_s = sync2_reg[2];
   assign tx_clk_s = sync2_reg[3];
   assign tx_en_s = sync2_reg[4];
   assign speed_s = sync2_reg[5];
   assign strap_s = sync2_reg[PIN_W-1:6];

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         mdc_prev_reg <= 1'b1;
         tx_clk_prev_reg <= 1'b1;
         tx_en_prev_reg <= 1'b0;
      end
      else
      begin
         mdc_prev_reg <= mdc_s;
         tx_clk_prev_reg <= tx_clk_s;
         tx_en_prev_reg <= tx_en_s;
      end
   end

   // hard pin and soft request both hold the sequence while asserted
   assign in_reset = !hard_n_s || soft_reset;

   assign latch_now = (state_reg == PBSS_POWER || state_reg == PBSS_SETTLE)
                      && (cnt_reg == '0) && !in_reset;
   assign drive_now = (state_reg == PBSS_TURN) && (cnt_reg == '0)
                      && !in_reset;

   // sequencer: power wait or reset wait, latch, turnaround, run
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_reg <= PBSS_POWER;
         cnt_reg <= CNT_W'(POWER_CYC - 1);
      end
      else if (in_reset)
      begin
         state_reg <= PBSS_HOLD;
         cnt_reg <= CNT_W'(RESET_LATCH_CYC - 1);
      end
      else
      begin
         unique case (state_reg)
            PBSS_POWER, PBSS_SETTLE:
            begin
               if (cnt_reg == '0)
               begin
                  state_reg <= PBSS_TURN;
                  cnt_reg <= CNT_W'(DRIVE_TURN_CYC - 1);
               end
               else
               begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end
            end
            PBSS_HOLD:
            begin
               // count already loaded; release starts the settle wait
               state_reg <= PBSS_SETTLE;
               cnt_reg <= cnt_reg - CNT_W'(1);
            end
            PBSS_TURN:
            begin
               if (cnt_reg == '0)
               begin
                  state_reg <= PBSS_RUN;
               end
               else
               begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end
            end
            PBSS_RUN:
            begin
               state_reg <= PBSS_RUN;
            end
         endcase
      end
   end

   // strap capture; the old value stays visible but marked invalid in reset
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         strap_value_reg <= '0;
         straps_valid_reg <= STRAPS_VALID_RST;
      end
      else if (in_reset)
      begin
         straps_valid_reg <= 1'b0;
      end
      else if (latch_now)
      begin
         strap_value_reg <= strap_s;
         straps_valid_reg <= 1'b1;
      end
   end

   // pins released while in reset so the resistors can set the levels
   always_ff @(posedge ref_clk)
   begin
      if (reset || in_reset)
      begin
         strap_oe_reg <= {STRAP_W{STRAP_OE_RST}};
      end
      else if (drive_now)
      begin
         strap_oe_reg <= '1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         strap_out_reg <= '0;
      end
      else
      begin
         strap_out_reg <= func_out;
      end
   end

   // preamble is only honoured once the stabilization wait is over
   assign mgmt.enable = straps_valid_reg && !in_reset;
   assign mgmt.mdc_rise = mdc_s && !mdc_prev_reg;
   assign mgmt.mdio_bit = mdio_s;

   pbss_preamble_det u_det
   (
      .ref_clk(ref_clk),
      .reset(reset),
      .mgmt(mgmt)
   );

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         mgmt_ready_reg <= 1'b0;
      end
      else
      begin
         mgmt_ready_reg <= mgmt.enable && mgmt.preamble_seen;
      end
   end

   // hold time at the pin is zero, so enable is taken from the sample
   // before the rise; the mac must have it settled a reference cycle early
   assign tx_rise = tx_clk_s && !tx_clk_prev_reg;
   assign tx_level_next = tx_rise ? tx_en_prev_reg
                          : tx_level_reg;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         tx_level_reg <= 1'b0;
      end
      else
      begin
         tx_level_reg <= tx_level_next;
      end
   end

   // synchroniser latency counts toward the six bit times and the last
   // stage is the output flop; the edge is only resolved to one cycle
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         tx_pipe_reg <= '0;
      end
      else
      begin
         tx_pipe_reg[0] <= tx_level_next && speed_s
                           && (state_reg == PBSS_RUN);
         for (int i = 1; i < TX_PIPE_CYC; i++)
         begin
            tx_pipe_reg[i] <= tx_pipe_reg[i-1];
         end
      end
   end

   assign strap_out = strap_out_reg;
   assign strap_oe = strap_oe_reg;
   assign strap_value = strap_value_reg;
   assign straps_valid = straps_valid_reg;
   assign mgmt_ready = mgmt_ready_reg;
   assign line_tx_active = tx_pipe_reg[TX_PIPE_CYC-1];

endmodule

// ### pbss_properties.sv
`timescale 1ns/1ps
module pbss_properties
   import pbss_pkg::*;
#(
   parameter int STRAP_W = 8,
   parameter int POWER_CYC = POWER_LATCH_CYC
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic hard_reset_n,
   input wire logic soft_reset,
   input wire logic [STRAP_W-1:0] func_out,
   input wire logic [STRAP_W-1:0] strap_out,
   input wire logic [STRAP_W-1:0] strap_oe,
   input wire logic [STRAP_W-1:0] strap_value,
   input wire logic straps_valid,
   input wire logic mgmt_ready,
   input wire logic speed_100,
   input wire logic line_tx_active
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // saturates so the on-time check fires once per power-up only
   int pwr_cnt_reg;
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         pwr_cnt_reg <= 0;
      else if (pwr_cnt_reg < POWER_CYC + 3)
         pwr_cnt_reg <= pwr_cnt_reg + 1;
   end
   sequence s_oe_turn;
      !(|strap_oe) [*3] ##1 (&strap_oe);
   endsequence
   sequence s_hard_low;
      !hard_reset_n [*3];
   endsequence
   sequence s_slow;
      !speed_100 [*4];
   endsequence
   a_latch_early:
   assert property (pwr_cnt_reg < POWER_CYC - 1 |-> !straps_valid)
      else $error("straps latched early");
   a_latch_late:
   assert property (pwr_cnt_reg == POWER_CYC + 2 |-> straps_valid)
      else $error("straps latched late");
   a_oe_turn:
   assert property ($rose(straps_valid) |-> s_oe_turn)
      else $error("driver turnaround wrong");
   a_oe_valid:
   assert property (|strap_oe |-> straps_valid)
      else $error("pins driven before latch");
   a_out_copy:
   assert property (&strap_oe |-> strap_out == $past(func_out))
      else $error("pin value not func_out");
   a_soft_drop:
   assert property (soft_reset |=> !straps_valid && !(|strap_oe))
      else $error("soft reset not honoured");
   a_hard_drop:
   assert property (s_hard_low |=> !straps_valid && !(|strap_oe))
      else $error("hard reset not honoured");
   a_value_hold:
   assert property (straps_valid && $past(straps_valid)
      |-> $stable(strap_value))
      else $error("latched straps changed");
   a_ready_valid:
   assert property (mgmt_ready |-> straps_valid || $past(straps_valid))
      else $error("ready without latch");
   a_tx_quiet:
   assert property (s_slow |-> !line_tx_active)
      else $error("line active at low speed");
endmodule

// ### pbss_ctrl_model.sv
`timescale 1ns/1ps
module pbss_ctrl_model
(
   output logic mdc,
   output logic mdio,
   output logic tx_clk,
   output logic tx_en
);
   initial
   begin
      mdc = 1'b0;
      mdio = 1'b1;
      tx_en = 1'b0;
      tx_clk = 1'b0;
      #7;
      forever #80 tx_clk = ~tx_clk;
   end
   // mdc stands still between frames; mdio held 80 ns around each rise
   task automatic preamble(input int ones, input bit zero_tail);
      for (int i = 0; i < ones + zero_tail; i++)
      begin
         mdio = (i < ones);
         #80 mdc = 1'b1;
         #80 mdc = 1'b0;
      end
      mdio = 1'b1; // released, pull-up keeps it high
   endtask
   task automatic frame(input int len);
      @(posedge tx_clk);
      #2 tx_en = 1'b1;
      repeat (len) @(posedge tx_clk);
      #2 tx_en = 1'b0;
   endtask
endmodule

// ### tb_phy_bringup_strap_sequencer.sv
`timescale 1ns/1ps
module tb_phy_bringup_strap_sequencer
   import pbss_pkg::*;
;
   localparam int PCYC = 400;
   logic ref_clk = 1'b0, reset = 1'b1, hard_reset_n = 1'b1;
   logic soft_reset = 1'b0, speed_100 = 1'b0;
   logic [7:0] strap_ext = 8'h00, func_out = 8'h00;
   logic [7:0] strap_in, strap_out, strap_oe, strap_value;
   logic straps_valid, mdc, mdio_in, mgmt_ready, tx_clk, tx_en;
   logic line_tx_active;
   logic [31:0] seed = 32'hbb7f;
   logic [7:0] exp_q[$];
   int n, n_mismatch = 0, checked = 0;
   // shared pin: resistor level until the device drives it
   assign strap_in = (strap_oe & strap_out) | (~strap_oe & strap_ext);
   initial forever #10 ref_clk = ~ref_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   always @(posedge ref_clk)
   begin
      seed <= lfsr(seed);
      func_out <= seed[15:8];
   end
   pbss_top #(.STRAP_W(8), .POWER_CYC(PCYC)) dut_u (.ref_clk(ref_clk),
      .reset(reset), .hard_reset_n(hard_reset_n), .soft_reset(soft_reset),
      .strap_in(strap_in), .func_out(func_out), .strap_out(strap_out),
      .strap_oe(strap_oe), .strap_value(strap_value),
      .straps_valid(straps_valid), .mdc(mdc), .mdio_in(mdio_in),
      .mgmt_ready(mgmt_ready), .speed_100(speed_100), .tx_clk(tx_clk),
      .tx_en(tx_en), .line_tx_active(line_tx_active));
   pbss_ctrl_model ctl_u (.mdc(mdc), .mdio(mdio_in), .tx_clk(tx_clk),
      .tx_en(tx_en));
   task automatic wrap_up();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_win(input int got, input int lo, input int hi);
      checked++;
      if (got < lo || got > hi)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   function automatic logic obs(input int sel);
      case (sel)
         0: return straps_valid;
         1: return mgmt_ready;
         default: return line_tx_active;
      endcase
   endfunction
   task automatic wait_for(input int sel, input logic v, input int lim,
      output int k);
      k = 0;
      do
      begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      while (obs(sel) !== v && k < lim);
   endtask
   logic [7:0] fo_exp;
   // a reset must not land inside the turnaround, so wait it out here
   task automatic oe_check();
      repeat (4) @(posedge ref_clk);
      #1;
      cmp_val(strap_oe, 8'hff);
      fo_exp = func_out;
      @(posedge ref_clk);
      #1;
      cmp_val(strap_out, fo_exp);
   endtask
   task automatic tx_check(input logic fast, input int len);
      int k;
      @(posedge ref_clk);
      speed_100 <= fast;
      repeat (8) @(posedge ref_clk);
      fork
         ctl_u.frame(len);
      join_none
      wait (tx_en === 1'b1);
      @(posedge tx_clk);
      wait_for(2, 1'b1, 40, k);
      cmp_win(k, fast ? TX_LAT_CYC - 1 : 40,
         fast ? TX_LAT_CYC + 1 : 40);
      wait (tx_en === 1'b0);
      @(posedge tx_clk);
      wait_for(2, 1'b0, 40, k);
      cmp_win(k, fast ? TX_LAT_CYC - 1 : 1,
         fast ? TX_LAT_CYC + 1 : 1);
   endtask
   // redo pulses reset again mid-wait, so the count must restart
   task automatic relatch(input bit hard, input int hold, input bit redo);
      int k;
      @(posedge ref_clk);
      strap_ext <= seed[7:0];
      exp_q.push_back(seed[7:0]);
      for (int i = 0; i <= redo; i++)
      begin
         if (hard)
            hard_reset_n <= 1'b0;
         else
            soft_reset <= 1'b1;
         repeat (hold) @(posedge ref_clk);
         hard_reset_n <= 1'b1;
         soft_reset <= 1'b0;
         if (i < redo)
            repeat (60) @(posedge ref_clk);
      end
      wait_for(0, 1'b1, 400, k);
      cmp_win(k, RESET_LATCH_CYC - 1 + 2 * hard,
         RESET_LATCH_CYC + 3 + 2 * hard);
      cmp_val(strap_value, exp_q.pop_front());
      cmp_val({7'h00, mgmt_ready}, 8'h00);
      oe_check();
   endtask
   initial
   begin
      #200000;
      n_mismatch++;
      wrap_up();
   end
   initial
   begin
      strap_ext = seed[7:0];
      exp_q.push_back(seed[7:0]);
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      fork
         ctl_u.preamble(32, 1'b0);
         wait_for(0, 1'b1, 2 * PCYC, n);
      join
      cmp_win(n, PCYC - 1, PCYC + 2);
      cmp_val(strap_value, exp_q.pop_front());
      oe_check();
      cmp_val({7'h00, mgmt_ready}, 8'h00);
      ctl_u.preamble(20, 1'b1);
      ctl_u.preamble(31, 1'b0);
      repeat (8) @(posedge ref_clk);
      cmp_val({7'h00, mgmt_ready}, 8'h00);
      ctl_u.preamble(1, 1'b0);
      wait_for(1, 1'b1, 10, n);
      cmp_win(n, 1, 6);
      tx_check(1'b1, 6);
      tx_check(1'b0, 4);
      relatch(1'b0, 5, 1'b0);
      relatch(1'b0, 5, 1'b1);
      relatch(1'b1, 60, 1'b0);
      ctl_u.preamble(32, 1'b0);
      wait_for(1, 1'b1, 10, n);
      cmp_win(n, 1, 6);
      wrap_up();
   end
endmodule
bind pbss_top pbss_properties #(.STRAP_W(STRAP_W), .POWER_CYC(POWER_CYC)) chk_u
(
   .ref_clk(ref_clk), .reset(reset), .hard_reset_n(hard_reset_n),
   .soft_reset(soft_reset), .func_out(func_out), .strap_out(strap_out),
   .strap_oe(strap_oe), .strap_value(strap_value),
   .straps_valid(straps_valid), .mgmt_ready(mgmt_ready),
   .speed_100(speed_100), .line_tx_active(line_tx_active)
);
